// ===== cod_object_dictionary.sv
// Purpose: communication entries of the object dictionary
// Assumes: requests come from the service-data handler on clk_i;
//          node address comes from switches and is synchronised here
// Notes:   answer one cycle after each request
//
// Function
// - device type entry is read-only and always reads zero.
// - 8-bit error summary: bit 0 general, bit 4 communication, read-only.
// - error history reports count and two newest emergency codes, read-only.
// - writable sync identifier, reset 80h, used to recognise sync frames.
// - emergency identifier reads 80h plus node address, read-only.
// - 16-bit emergency inhibit time, reset zero, read-only.
// - two writable heartbeat consumer records; subentry 0 reads 2.
// - heartbeat sent every producer period in ms; zero sends none.
// - identity has four read-only subentries; revision, serial read zero.
// - receive object identifier 200h plus node, type reset FFh, writable.
// - transmit object 180h plus node, type FFh, inhibit 1000, event 0.
// - process-data mappings are fixed and read-only.
`timescale 1ns/1ps
module cod_object_dictionary #(
    parameter int          MS_CYCLES   = cod_pkg::MS_CYCLES,
    parameter logic [31:0] VENDOR_CODE = 32'h0000_0001, // arbitrary value
    parameter logic [31:0] PRODUCT_CODE = 32'h0000_0002 // arbitrary value
)
(
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic [6:0]  node_addr_i,
    input  wire logic        req_valid_i,
    input  wire logic        req_write_i,
    input  wire logic [15:0] req_index_i,
    input  wire logic [7:0]  req_sub_i,
    input  wire logic [31:0] req_wdata_i,
    output logic             rsp_valid_o,
    output logic             rsp_abort_o,
    output logic [31:0]      rsp_rdata_o,
    input  wire logic        rx_valid_i,
    input  wire logic        rx_rtr_i,
    input  wire logic [10:0] rx_cob_i,
    input  wire logic        emcy_valid_i,
    input  wire logic [31:0] emcy_code_i,
    input  wire logic        err_general_i,
    input  wire logic        err_comm_i,
    output logic             sync_o,
    output logic             rx_pdo_o,
    output logic             guard_req_o,
    output logic             hb_send_o,
    output logic             tx_event_o,
    output logic             guard_lost_o
);
    initial
    begin
        if (MS_CYCLES < 2)
            $error("MS_CYCLES must be at least 2");
    end

    localparam int PW = $clog2(MS_CYCLES);

    // node address from the switches: two stages before use
    logic [6:0]  node_meta_q;
    logic [6:0]  node_q;
    always_ff @(posedge clk_i)
    begin
        node_meta_q <= node_addr_i;
        node_q      <= node_meta_q;
    end

    logic [31:0] node_w;
    assign node_w = {25'h0, node_q};

    // writable storage
    logic [31:0] sync_identifier_q;
    logic [31:0] cycle_q;
    logic [31:0] window_q;
    logic [15:0] guard_q;
    logic [7:0]  life_q;
    logic [31:0] hbc_q [2];
    logic [15:0] hbp_q;
    logic        rx_id_set_q;
    logic [31:0] rx_id_q;
    logic [7:0]  rx_type_q;
    logic        tx_id_set_q;
    logic [31:0] tx_id_q;
    logic [7:0]  tx_type_q;
    logic [15:0] tx_inhibit_q;
    logic [15:0] tx_event_q;
    // hardware-owned state
    logic [7:0]  err_q;
    logic [31:0] hist_q [2];
    logic [7:0]  hist_cnt_q;
    logic        guard_armed_q;
    logic        guard_lost_q;

    // ids in force: track the node until written
    logic [31:0] rx_id_w;
    logic [31:0] tx_id_w;
    logic [31:0] emergency_identifier_w;
    assign rx_id_w   = rx_id_set_q ? rx_id_q : cod_pkg::RX_PDO_BASE + node_w;
    assign tx_id_w   = tx_id_set_q ? tx_id_q : cod_pkg::TX_PDO_BASE + node_w;
    assign emergency_identifier_w = cod_pkg::EMCY_BASE + node_w;

    logic [23:0] key_w;
    logic        wr_w;
    logic        rd_ok;
    logic        wr_ok;
    logic [31:0] rd_data;
    assign key_w = cod_pkg::cod_key(req_index_i, req_sub_i);

    // read decode and write permission; unmapped keys refuse both
    always_comb
    begin
        rd_ok   = 1'b1;
        wr_ok   = 1'b0;
        rd_data = 32'h0000_0000;
        unique case (req_index_i)
            cod_pkg::IDX_DEVICE_TYPE:
                rd_ok = (req_sub_i == 8'h00);
            cod_pkg::IDX_ERROR_SUMMARY:
            begin
                rd_ok   = (req_sub_i == 8'h00);
                rd_data = {24'h0, err_q};
            end
            cod_pkg::IDX_ERROR_HISTORY:
            begin
                unique case (req_sub_i)
                    8'h00:   rd_data = {24'h0, hist_cnt_q};
                    8'h01:   rd_data = hist_q[0];
                    8'h02:   rd_data = hist_q[1];
                    default: rd_ok = 1'b0;
                endcase
            end
            cod_pkg::IDX_SYNC_IDENTIFIER:
            begin
                rd_ok   = (req_sub_i == 8'h00);
                wr_ok   = rd_ok;
                rd_data = sync_identifier_q;
            end
            cod_pkg::IDX_CYCLE_PERIOD:
            begin
                rd_ok   = (req_sub_i == 8'h00);
                wr_ok   = rd_ok;
                rd_data = cycle_q;
            end
            cod_pkg::IDX_SYNC_WINDOW:
            begin
                rd_ok   = (req_sub_i == 8'h00);
                wr_ok   = rd_ok;
                rd_data = window_q;
            end
            cod_pkg::IDX_GUARD_INT:
            begin
                rd_ok   = (req_sub_i == 8'h00);
                wr_ok   = rd_ok;
                rd_data = {16'h0, guard_q};
            end
            cod_pkg::IDX_LIFETIME:
            begin
                rd_ok   = (req_sub_i == 8'h00);
                wr_ok   = rd_ok;
                rd_data = {24'h0, life_q};
            end
            cod_pkg::IDX_EMERGENCY_IDENTIFIER:
            begin
                rd_ok   = (req_sub_i == 8'h00);
                rd_data = emergency_identifier_w;
            end
            cod_pkg::IDX_EMCY_HOLDOFF:
            begin
                rd_ok   = (req_sub_i == 8'h00);
                rd_data = {16'h0, cod_pkg::EMCY_HOLD_RST};
            end
            cod_pkg::IDX_HB_CONSUMER:
            begin
                unique case (req_sub_i)
                    8'h00:   rd_data = {24'h0, cod_pkg::HB_CONS_COUNT};
                    8'h01:   rd_data = hbc_q[0];
                    8'h02:   rd_data = hbc_q[1];
                    default: rd_ok = 1'b0;
                endcase
                wr_ok = rd_ok && req_sub_i != 8'h00;
            end
            cod_pkg::IDX_HB_PRODUCER:
            begin
                rd_ok   = (req_sub_i == 8'h00);
                wr_ok   = rd_ok;
                rd_data = {16'h0, hbp_q};
            end
            cod_pkg::IDX_IDENTITY:
            begin
                unique case (req_sub_i)
                    8'h00:   rd_data = {24'h0, cod_pkg::IDENT_COUNT};
                    8'h01:   rd_data = VENDOR_CODE;
                    8'h02:   rd_data = PRODUCT_CODE;
                    8'h03:   rd_data = 32'h0000_0000;
                    8'h04:   rd_data = 32'h0000_0000;
                    default: rd_ok = 1'b0;
                endcase
            end
            cod_pkg::IDX_RX_COMM:
            begin
                unique case (req_sub_i)
                    8'h00:   rd_data = {24'h0, cod_pkg::RX_COMM_COUNT};
                    8'h01:   rd_data = rx_id_w;
                    8'h02:   rd_data = {24'h0, rx_type_q};
                    default: rd_ok = 1'b0;
                endcase
                wr_ok = rd_ok && req_sub_i != 8'h00;
            end
            cod_pkg::IDX_TX_COMM:
            begin
                unique case (req_sub_i)
                    8'h00:   rd_data = {24'h0, cod_pkg::TX_COMM_COUNT};
                    8'h01:   rd_data = tx_id_w;
                    8'h02:   rd_data = {24'h0, tx_type_q};
                    8'h03:   rd_data = {16'h0, tx_inhibit_q};
                    8'h05:   rd_data = {16'h0, tx_event_q};
                    default: rd_ok = 1'b0;
                endcase
                wr_ok = rd_ok && req_sub_i != 8'h00;
            end
            cod_pkg::IDX_RX_MAP:
            begin
                unique case (req_sub_i)
                    8'h00:   rd_data = {24'h0, cod_pkg::MAP_COUNT};
                    8'h01:   rd_data = cod_pkg::RX_MAP1;
                    8'h02:   rd_data = cod_pkg::RX_MAP2;
                    8'h03:   rd_data = cod_pkg::RX_MAP3;
                    default: rd_ok = 1'b0;
                endcase
            end
            cod_pkg::IDX_TX_MAP:
            begin
                unique case (req_sub_i)
                    8'h00:   rd_data = {24'h0, cod_pkg::MAP_COUNT};
                    8'h01:   rd_data = cod_pkg::TX_MAP1;
                    8'h02:   rd_data = cod_pkg::TX_MAP2;
                    8'h03:   rd_data = cod_pkg::TX_MAP3;
                    default: rd_ok = 1'b0;
                endcase
            end
            default: rd_ok = 1'b0;
        endcase
    end

    assign wr_w = req_valid_i && req_write_i && wr_ok;

    // answer; refused access aborts
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rsp_valid_o <= 1'b0;
            rsp_abort_o <= 1'b0;
            rsp_rdata_o <= 32'h0000_0000;
        end
        else
        begin
            rsp_valid_o <= req_valid_i;
            rsp_abort_o <= req_valid_i && (req_write_i ? !wr_ok : !rd_ok);
            rsp_rdata_o <= (req_valid_i && !req_write_i && rd_ok)
                           ? rd_data : 32'h0000_0000;
        end
    end

    // comm parameters; narrow entries keep low bits
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sync_identifier_q <= cod_pkg::SYNC_IDENTIFIER_RST;
            cycle_q   <= 32'h0000_0000;
            window_q  <= 32'h0000_0000;
            guard_q   <= 16'h0000;
            life_q    <= 8'h00;
            hbc_q[0]  <= 32'h0000_0000;
            hbc_q[1]  <= 32'h0000_0000;
            hbp_q     <= cod_pkg::HB_PROD_RST;
        end
        else if (wr_w)
        begin
            unique case (req_index_i)
                cod_pkg::IDX_SYNC_IDENTIFIER:      sync_identifier_q <= req_wdata_i;
                cod_pkg::IDX_CYCLE_PERIOD: cycle_q   <= req_wdata_i;
                cod_pkg::IDX_SYNC_WINDOW:  window_q  <= req_wdata_i;
                cod_pkg::IDX_GUARD_INT:    guard_q   <= req_wdata_i[15:0];
                cod_pkg::IDX_LIFETIME:     life_q    <= req_wdata_i[7:0];
                cod_pkg::IDX_HB_CONSUMER:
                    hbc_q[req_sub_i[1]] <= req_wdata_i;
                cod_pkg::IDX_HB_PRODUCER:  hbp_q     <= req_wdata_i[15:0];
                default: ;
            endcase
        end
    end

    // process-data communication parameters
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rx_id_set_q  <= 1'b0;
            rx_id_q      <= 32'h0000_0000;
            rx_type_q    <= cod_pkg::PDO_TYPE_RST;
            tx_id_set_q  <= 1'b0;
            tx_id_q      <= 32'h0000_0000;
            tx_type_q    <= cod_pkg::PDO_TYPE_RST;
            tx_inhibit_q <= cod_pkg::TX_INHIBIT_RST;
            tx_event_q   <= 16'h0000;
        end
        else if (wr_w)
        begin
            unique case (key_w)
                cod_pkg::cod_key(cod_pkg::IDX_RX_COMM, 8'h01):
                begin
                    rx_id_set_q <= 1'b1;
                    rx_id_q     <= req_wdata_i;
                end
                cod_pkg::cod_key(cod_pkg::IDX_RX_COMM, 8'h02):
                    rx_type_q <= req_wdata_i[7:0];
                cod_pkg::cod_key(cod_pkg::IDX_TX_COMM, 8'h01):
                begin
                    tx_id_set_q <= 1'b1;
                    tx_id_q     <= req_wdata_i;
                end
                cod_pkg::cod_key(cod_pkg::IDX_TX_COMM, 8'h02):
                    tx_type_q <= req_wdata_i[7:0];
                cod_pkg::cod_key(cod_pkg::IDX_TX_COMM, 8'h03):
                    tx_inhibit_q <= req_wdata_i[15:0];
                cod_pkg::cod_key(cod_pkg::IDX_TX_COMM, 8'h05):
                    tx_event_q <= req_wdata_i[15:0];
                default: ;
            endcase
        end
    end

    // history: newest in sub 1, older moves to 2
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            hist_q[0]  <= 32'h0000_0000;
            hist_q[1]  <= 32'h0000_0000;
            hist_cnt_q <= 8'h00;
        end
        else if (emcy_valid_i)
        begin
            hist_q[0] <= emcy_code_i;
            hist_q[1] <= hist_q[0];
            if (hist_cnt_q != cod_pkg::HIST_DEPTH)
                hist_cnt_q <= hist_cnt_q + 8'h01;
        end
    end

    // frame match; id bit 31 marks a pdo unused
    logic rx_data_w;
    logic guard_frame_w;
    assign rx_data_w     = rx_valid_i && !rx_rtr_i;
    assign guard_frame_w = rx_valid_i && rx_rtr_i &&
                           rx_cob_i == 11'(cod_pkg::GUARD_BASE + node_w);
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sync_o      <= 1'b0;
            rx_pdo_o    <= 1'b0;
            guard_req_o <= 1'b0;
        end
        else
        begin
            sync_o      <= rx_data_w && rx_cob_i == sync_identifier_q[10:0];
            rx_pdo_o    <= rx_data_w && !rx_id_w[31] &&
                           rx_cob_i == rx_id_w[10:0];
            guard_req_o <= guard_frame_w;
        end
    end

    // one ms prescaler shared by all timers
    logic [PW-1:0] pre_q;
    logic          ms_q;
    always_ff @(posedge clk_i)
    begin
        if (srst_i || pre_q == PW'(MS_CYCLES - 1))
            pre_q <= '0;
        else
            pre_q <= pre_q + 1'b1;
        ms_q <= !srst_i && pre_q == PW'(MS_CYCLES - 1);
    end

    cod_tick_if #(.W(16)) hb_t (.clk(clk_i), .rst(srst_i));
    cod_tick_if #(.W(24)) gd_t (.clk(clk_i), .rst(srst_i));
    cod_tick_if #(.W(16)) ev_t (.clk(clk_i), .rst(srst_i));

    // zero period idles the timer: no beat
    assign hb_t.ms_tick = ms_q;
    assign hb_t.period  = hbp_q;
    assign hb_t.restart = 1'b0;
    // lifetime = guard period times factor
    assign gd_t.ms_tick = ms_q;
    assign gd_t.period  = guard_armed_q ? guard_q * life_q : 24'h0;
    assign gd_t.restart = guard_frame_w;
    assign ev_t.ms_tick = ms_q;
    assign ev_t.period  = tx_id_w[31] ? 16'h0000 : tx_event_q;
    assign ev_t.restart = 1'b0;

    cod_period_timer #(.W(16)) u_hb (.t(hb_t));
    cod_period_timer #(.W(24)) u_gd (.t(gd_t));
    cod_period_timer #(.W(16)) u_ev (.t(ev_t));

    // guarding arms on the first guard request; a late loss beats clear
    always_ff @(posedge clk_i)
    begin
        if (srst_i || guard_q == 16'h0000)
        begin
            guard_armed_q <= 1'b0;
            guard_lost_q  <= 1'b0;
        end
        else
        begin
            if (guard_frame_w)
                guard_armed_q <= 1'b1;
            if (gd_t.expire)
                guard_lost_q <= 1'b1;
            else if (guard_frame_w)
                guard_lost_q <= 1'b0;
        end
    end

    // event outputs and error summary
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            hb_send_o    <= 1'b0;
            tx_event_o   <= 1'b0;
            guard_lost_o <= 1'b0;
            err_q        <= 8'h00;
        end
        else
        begin
            hb_send_o    <= hb_t.expire;
            tx_event_o   <= ev_t.expire;
            guard_lost_o <= guard_lost_q;
            err_q <= ((err_general_i || emcy_valid_i) ? cod_pkg::ERR_BIT_GEN
                      : 8'h00) |
                     ((err_comm_i || guard_lost_q) ? cod_pkg::ERR_BIT_COMM
                      : 8'h00);
        end
    end

endmodule

// ===== cod_pkg.sv
// Purpose: constants shared by the object dictionary and its timers
// Assumes: 200 MHz system clock
// Notes:   indexes are dictionary addresses, not byte addresses
package cod_pkg;

    // clock and millisecond base
    localparam int CLK_PERIOD_PS = 5000;
    localparam int MS_PERIOD_PS  = 1000000000;
    localparam int MS_CYCLES     = MS_PERIOD_PS / CLK_PERIOD_PS;

    // dictionary indexes
    localparam logic [15:0] IDX_DEVICE_TYPE   = 16'h1000;
    localparam logic [15:0] IDX_ERROR_SUMMARY = 16'h1001;
    localparam logic [15:0] IDX_ERROR_HISTORY = 16'h1003;
    localparam logic [15:0] IDX_SYNC_IDENTIFIER       = 16'h1005;
    localparam logic [15:0] IDX_CYCLE_PERIOD  = 16'h1006;
    localparam logic [15:0] IDX_SYNC_WINDOW   = 16'h1007;
    localparam logic [15:0] IDX_GUARD_INT     = 16'h100C;
    localparam logic [15:0] IDX_LIFETIME      = 16'h100D;
    localparam logic [15:0] IDX_EMERGENCY_IDENTIFIER       = 16'h1014;
    localparam logic [15:0] IDX_EMCY_HOLDOFF  = 16'h1015;
    localparam logic [15:0] IDX_HB_CONSUMER   = 16'h1016;
    localparam logic [15:0] IDX_HB_PRODUCER   = 16'h1017;
    localparam logic [15:0] IDX_IDENTITY      = 16'h1018;
    localparam logic [15:0] IDX_RX_COMM       = 16'h1400;
    localparam logic [15:0] IDX_RX_MAP        = 16'h1600;
    localparam logic [15:0] IDX_TX_COMM       = 16'h1800;
    localparam logic [15:0] IDX_TX_MAP        = 16'h1A00;

    // subentry counts reported in subentry 0; HIST_DEPTH caps the history count
    localparam logic [7:0] HIST_DEPTH    = 8'h02;
    localparam logic [7:0] HB_CONS_COUNT = 8'h02;
    localparam logic [7:0] IDENT_COUNT   = 8'h04;
    localparam logic [7:0] RX_COMM_COUNT = 8'h02;
    localparam logic [7:0] TX_COMM_COUNT = 8'h05;
    localparam logic [7:0] MAP_COUNT     = 8'h03;

    // reset values, identifier bases and error summary bits
    localparam logic [31:0] SYNC_IDENTIFIER_RST    = 32'h0000_0080;
    localparam logic [31:0] EMCY_BASE      = 32'h0000_0080;
    localparam logic [31:0] RX_PDO_BASE    = 32'h0000_0200;
    localparam logic [31:0] TX_PDO_BASE    = 32'h0000_0180;
    localparam logic [31:0] GUARD_BASE     = 32'h0000_0700;
    localparam logic [15:0] HB_PROD_RST    = 16'h01F4;
    localparam logic [7:0]  PDO_TYPE_RST   = 8'hFF;
    localparam logic [15:0] TX_INHIBIT_RST = 16'h03E8;
    localparam logic [15:0] EMCY_HOLD_RST  = 16'h0000;
    localparam logic [7:0]  ERR_BIT_GEN    = 8'h01;
    localparam logic [7:0]  ERR_BIT_COMM   = 8'h10;

    // fixed process-data mappings
    localparam logic [31:0] RX_MAP1 = 32'h2024_0010;
    localparam logic [31:0] RX_MAP2 = 32'h0000_0010;
    localparam logic [31:0] RX_MAP3 = 32'h2001_0020;
    localparam logic [31:0] TX_MAP1 = 32'h2025_0010;
    localparam logic [31:0] TX_MAP2 = 32'h2030_0010;
    localparam logic [31:0] TX_MAP3 = 32'h2003_0020;

    // index and subentry as one key
    function automatic logic [23:0] cod_key(input logic [15:0] idx,
                                            input logic [7:0]  sub);
        return {idx, sub};
    endfunction

endpackage

// ===== cod_tick_if.sv
// Purpose: connects the dictionary to one millisecond period timer
// Assumes: single clock domain
// Notes:   a zero period disables the timer
`timescale 1ns/1ps
interface cod_tick_if #(parameter int W = 16)
(
    input wire logic clk,
    input wire logic rst
);
    logic         ms_tick;
    logic [W-1:0] period;
    logic         restart;
    logic         expire;

    modport owner (output ms_tick, output period, output restart,
                   input expire);
    modport timer (input clk, input rst, input ms_tick, input period,
                   input restart, output expire);
endinterface

// ===== cod_period_timer.sv
// Purpose: counts millisecond ticks and pulses once per period
// Assumes: ms_tick is a one-cycle pulse
// Notes:   period zero holds the count at zero and never expires
`timescale 1ns/1ps
module cod_period_timer #(parameter int W = 16)
(
    cod_tick_if.timer t
);
    initial
    begin
        if (W < 1 || W > 32)
            $error("timer width out of range");
    end

    logic [W-1:0] cnt_q;
    logic         exp_q;

    // restart or zero period clears the count
    always_ff @(posedge t.clk)
    begin
        if (t.rst || t.restart || t.period == '0)
        begin
            cnt_q <= '0;
            exp_q <= 1'b0;
        end
        else if (t.ms_tick && cnt_q >= t.period - 1'b1)
        begin
            cnt_q <= '0;
            exp_q <= 1'b1;
        end
        else
        begin
            if (t.ms_tick)
                cnt_q <= cnt_q + 1'b1;
            exp_q <= 1'b0;
        end
    end

    assign t.expire = exp_q;
endmodule

// ===== cod_master_model.sv
// Purpose: bus master model that sends frames to the dictionary
// Assumes: frames arrive on the system clock, one cycle each
// Notes:   idle id and flag scrambled
`timescale 1ns/1ps
module cod_master_model
(
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic        rtr_i,
    input  wire logic [10:0] cob_i,
    output logic             rx_valid_o,
    output logic             rx_rtr_o,
    output logic [10:0]      rx_cob_o
);
    // stale id inverted so none matches by luck
    always_ff @(posedge clk_i)
    begin
        rx_valid_o <= go_i;
        rx_rtr_o   <= go_i ? rtr_i : !rx_rtr_o;
        rx_cob_o   <= go_i ? cob_i : ~rx_cob_o;
    end
endmodule

// ===== cod_object_dictionary_sva.sv
// Purpose: port checks of the dictionary
// Assumes: one clock, reset high
// Notes:   bound from the bench
`timescale 1ns/1ps
module cod_object_dictionary_sva
(
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        req_valid_i,
    input wire logic        req_write_i,
    input wire logic [15:0] req_index_i,
    input wire logic [7:0]  req_sub_i,
    input wire logic        rsp_abort_o,
    input wire logic [31:0] rsp_rdata_o,
    input wire logic        rx_valid_i,
    input wire logic        rx_rtr_i,
    input wire logic        sync_o,
    input wire logic        rx_pdo_o,
    input wire logic        hb_send_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    logic        rd;
    logic        wr;
    logic [23:0] k;
    // decoded request
    assign rd = req_valid_i && !req_write_i;
    assign wr = req_valid_i && req_write_i;
    assign k  = {req_index_i, req_sub_i};
    chk_devtype_zero: assert property
        (rd && k == 24'h100000 |=> !rsp_abort_o && rsp_rdata_o == 32'h0)
        else $error("devtype read");
    chk_devtype_ro: assert property
        (wr && req_index_i == 16'h1000 |=> rsp_abort_o)
        else $error("devtype write");
    chk_errsum_bits: assert property
        (rd && k == 24'h100100 |=> (rsp_rdata_o & 32'hFFFF_FFEE) == 32'h0)
        else $error("errsum spare bits");
    chk_rtr_ignored: assert property
        (rx_valid_i && rx_rtr_i |=> !sync_o && !rx_pdo_o)
        else $error("rtr taken");
    chk_emcy_ro: assert property
        (wr && req_index_i == 16'h1014 |=> rsp_abort_o)
        else $error("emcy write");
    chk_holdoff_zero: assert property
        (rd && k == 24'h101500 |=> !rsp_abort_o && rsp_rdata_o == 32'h0)
        else $error("inhibit not zero");
    chk_hbcons_count: assert property
        (rd && k == 24'h101600 |=> rsp_rdata_o == 32'h2)
        else $error("hb count");
    chk_hb_spacing: assert property
        (hb_send_o |=> !hb_send_o [*8])
        else $error("hb too close");
    chk_ident_zero: assert property
        (rd && (k == 24'h101803 || k == 24'h101804) |=> rsp_rdata_o == 32'h0)
        else $error("ident not zero");
    chk_map_ro: assert property
        (wr && (req_index_i == 16'h1600 || req_index_i == 16'h1A00)
            |=> rsp_abort_o)
        else $error("map write");
endmodule

// ===== canopen_object_dictionary_bench.sv
// Purpose: self-checking bench of the object dictionary
// Assumes: millisecond shortened to 20 clocks
// Notes:   model keeps value and width per key; width 0 is read-only
`timescale 1ns/1ps
module canopen_object_dictionary_bench;
    logic        clk_i = 0, srst_i = 1, req_valid_i = 0, req_write_i = 0;
    logic        emcy_valid_i = 0, err_general_i = 0, err_comm_i = 0;
    logic        go = 0, rtr = 0, ab, rx_valid_i, rx_rtr_i, rsp_valid_o;
    logic        rsp_abort_o, sync_o, rx_pdo_o, guard_req_o, hb_send_o;
    logic        tx_event_o, guard_lost_o;
    logic [6:0]  node_addr_i;
    logic [7:0]  req_sub_i = 0;
    logic [10:0] cob = 0, rx_cob_i;
    logic [15:0] req_index_i = 0;
    logic [31:0] req_wdata_i = 0, emcy_code_i = 0, rsp_rdata_o, rd, r;
    int          miscompares = 0, samples_checked = 0, cyc = 0, n;
    int          seed = 32'h0D5C1B8D;
    logic [31:0] mv [int];
    int          mw [int];
    logic [31:0] vs [18];
    int          ks [18] = '{24'h100000, 24'h100100, 24'h100300, 24'h100301,
        24'h100302, 24'h100500, 24'h100C00, 24'h100D00, 24'h101400,
        24'h101500, 24'h101600, 24'h101601, 24'h101700, 24'h101804,
        24'h140001, 24'h140002, 24'h160003, 24'h180003};
    int          ws [18] = '{0, 0, 0, 0, 0, 32, 16, 8, 0, 0, 0, 32, 16, 0,
        32, 8, 0, 16};

    cod_object_dictionary #(.MS_CYCLES(20)) i_dut (.*);
    cod_master_model i_far (.clk_i(clk_i), .go_i(go), .rtr_i(rtr),
        .cob_i(cob), .rx_valid_o(rx_valid_i), .rx_rtr_o(rx_rtr_i),
        .rx_cob_o(rx_cob_i));

    // clock and hang guard
    always #2.5 clk_i = !clk_i;
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            print_verdict;
        end
    end

    task automatic chk(input string s, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s exp %h seen %h", s, exp, seen);
        end
    endtask

    task automatic acc(input logic w, input int k, input logic [31:0] d);
        @(posedge clk_i);
        req_valid_i <= 1;
        req_write_i <= w;
        {req_index_i, req_sub_i} <= k[23:0];
        req_wdata_i <= d;
        @(posedge clk_i);
        req_valid_i <= 0;
        @(negedge clk_i);
        chk("answer", rsp_valid_o, 32'h1);
        rd = rsp_rdata_o;
        ab = rsp_abort_o;
    endtask

    task automatic probe(input int k);
        acc(0, k, 0);
        chk($sformatf("rd %h", k), rd, mv[k]);
        chk("rd abort", ab, 32'h0);
    endtask

    // refused writes leave the model
    task automatic wr(input int k, input logic [31:0] d);
        acc(1, k, d);
        chk("wr abort", ab, mw[k] == 0);
        if (mw[k] != 0)
            mv[k] = d & ((64'h1 << mw[k]) - 1);
    endtask

    task automatic send(input logic [10:0] c, input logic t);
        @(posedge clk_i);
        go <= 1;
        cob <= c;
        rtr <= t;
        @(posedge clk_i);
        go <= 0;
        @(posedge clk_i);
        @(negedge clk_i);
    endtask

    // cycles to next beat, capped for a silent timer
    task automatic gap(output int c);
        c = 0;
        do
            @(negedge clk_i);
        while (!hb_send_o && ++c < 3000);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // main sequence
    initial
    begin
        n = {$random(seed)} % 127 + 1;
        node_addr_i = n[6:0];
        vs = '{0, 0, 0, 0, 0, 32'h80, 0, 0, 32'h80 + n, 0, 2, 0, 32'h1F4,
               0, 32'h200 + n, 32'hFF, 32'h2001_0020, 32'h3E8};
        foreach (ks[i])
        begin
            mv[ks[i]] = vs[i];
            mw[ks[i]] = ws[i];
        end
        repeat (20) @(posedge clk_i);
        srst_i <= 0;
        foreach (ks[i])
            probe(ks[i]);
        acc(0, 24'h100001, 0);
        chk("sub abort", ab, 32'h1);
        foreach (ks[i])
        begin
            r = $random(seed);
            wr(ks[i], r);
            probe(ks[i]);
        end
        send(mv[24'h100500][10:0], 0);
        chk("sync", sync_o, 32'h1);
        send(mv[24'h140001][10:0], 0);
        chk("pdo", rx_pdo_o, !mv[24'h140001][31]);
        send(mv[24'h100500][10:0], 1);
        repeat (2)
        begin
            @(posedge clk_i);
            emcy_valid_i <= 1;
            emcy_code_i <= $random(seed);
            @(posedge clk_i);
            emcy_valid_i <= 0;
            mv[24'h100302] = mv[24'h100301];
            mv[24'h100301] = emcy_code_i;
        end
        err_general_i <= 1;
        err_comm_i <= 1;
        mv[24'h100100] = 32'h11;
        mv[24'h100300] = 32'h2;
        repeat (3) @(posedge clk_i);
        foreach (ks[i])
            if (ks[i] < 24'h100500)
                probe(ks[i]);
        wr(24'h101700, 2);
        gap(n);
        gap(n);
        chk("hb gap", n, 39);
        wr(24'h101700, 0);
        gap(n);
        chk("hb off", n, 3000);
        print_verdict;
    end
endmodule

bind cod_object_dictionary cod_object_dictionary_sva i_chk (.*);
